/* File: src/lpf_fir_top.sv */
// lpf_fir_top.sv: polyphase linear phase fir with apb coefficient access
//
// Chosen here: the APB register port and the register addresses.
module lpf_fir_top
  import lpf_pkg::*;
#(
  parameter int ORDER     = LPF_ORDER_DEF,     // filter order, even
  parameter int LANES     = LPF_LANES_DEF,     // samples per data word
  parameter int SAMPLE_W  = LPF_SAMPLE_W_DEF,  // bits per sample
  parameter int COEF_W    = LPF_COEF_W_DEF,    // bits per coefficient
  parameter int COEF_FRAC = LPF_COEF_FRAC_DEF  // fractional bits
) (
  input  wire logic                      sys_clk,   // data clock
  input  wire logic                      sys_rst,   // sync reset, high
  input  wire lpf_apb_req_t              apbReq,    // apb request
  output logic      [LPF_APB_DW-1:0]     prdata,    // apb read data
  output logic                           pready,    // apb ready
  output logic                           pslverr,   // apb error
  input  wire logic [LANES*SAMPLE_W-1:0] dataIn,    // real-time word in
  output logic      [LANES*SAMPLE_W-1:0] dataOut,   // filtered word out
  output logic                           overRange  // some lane clipped
);

  // derived geometry
  localparam int G   = ORDER / 2;
  localparam int NC  = G + 1;
  localparam int D   = (G + LANES - 1) / LANES;
  localparam int L   = D * LANES;
  localparam int H   = 1 + (L + G + LANES - 1) / LANES;
  localparam int OFF = (H - 1) * LANES - L + G;
  localparam int PW  = SAMPLE_W + 1 + COEF_W;
  localparam int AW  = PW + lpf_ceil_log2(NC) + 1;
  localparam int WW  = LANES * SAMPLE_W;
  localparam logic [11:0] COEF_END = LPF_OFF_COEF0 + 12'(4 * NC);
  // unity gain centre tap, so a fresh part passes data through delayed
  localparam logic [NC*COEF_W-1:0] COEF_RST =
    (NC*COEF_W)'(1) << (G * COEF_W + COEF_FRAC);

  // parameter checks at elaboration
  if (ORDER % 2 != 0 || ORDER < 2) begin : g_bad_order
    $error("filter order must be even and at least two");
  end
  if (COEF_W > LPF_REG_CW) begin : g_bad_coef_w
    $error("coefficient wider than its register field");
  end
  if (COEF_FRAC < 1 || COEF_FRAC >= COEF_W) begin : g_bad_frac
    $error("fraction bits must be between one and width");
  end
  if (SAMPLE_W > 30 || ORDER > 255 || LANES > 255) begin : g_bad_size
    $error("sample width, order or lane count too large");
  end

  // bus side state
  logic                  ready_q;
  logic                  slvErr_q;
  logic [LPF_APB_DW-1:0] rdData_q;
  logic [LPF_APB_DW-1:0] rdData_d;
  logic                  hit_d;
  logic                  coefHit_d;
  logic [LPF_APB_AW-1:0] coefOff_d;
  logic                  bypass_q;
  logic                  load_q;
  logic                  sat_q;
  logic                  pend_q;
  logic [NC*COEF_W-1:0]  shadow_q;
  logic [NC*COEF_W-1:0]  coefVec;
  logic                  setup;
  logic                  wrAcc;
  logic                  wrCtrl;
  logic                  wrStat;
  logic                  wrCoef;

  // data side state
  logic [(H-1)*WW-1:0]   hist_q;
  logic [H*WW-1:0]       window;
  wire  [WW-1:0]         filt_d;
  wire  [LANES-1:0]      clip_d;
  logic [WW-1:0]         dataOut_q;
  logic                  ovr_q;

  // access phase before ready, and the edge at which a write lands
  assign setup  = apbReq.psel & apbReq.penable & ~ready_q;
  assign wrAcc  = apbReq.psel & apbReq.penable & ready_q & apbReq.pwrite;
  assign wrCtrl = wrAcc & (apbReq.paddr == LPF_OFF_CTRL);
  assign wrStat = wrAcc & (apbReq.paddr == LPF_OFF_STATUS);
  assign wrCoef = wrAcc & coefHit_d;

  // address decode and read mux
  always_comb begin
    hit_d     = 1'b1;
    coefHit_d = 1'b0;
    rdData_d  = '0;
    coefOff_d = apbReq.paddr - LPF_OFF_COEF0;
    if (apbReq.paddr == LPF_OFF_CTRL) begin
      rdData_d[LPF_CTRL_BYPASS_BIT] = bypass_q;
    end else if (apbReq.paddr == LPF_OFF_STATUS) begin
      rdData_d[LPF_STAT_SAT_BIT]  = sat_q;
      rdData_d[LPF_STAT_PEND_BIT] = pend_q;
    end else if (apbReq.paddr == LPF_OFF_INFO) begin
      rdData_d[LPF_INFO_ORDER_LSB +: 8] = 8'(ORDER);
      rdData_d[LPF_INFO_LANES_LSB +: 8] = 8'(LANES);
    end else if (apbReq.paddr >= LPF_OFF_COEF0 &&
                 apbReq.paddr < COEF_END &&
                 apbReq.paddr[1:0] == 2'h0) begin
      coefHit_d = 1'b1;
      rdData_d[COEF_W-1:0] =
        shadow_q[coefOff_d[LPF_APB_AW-1:2] * COEF_W +: COEF_W];
    end else begin
      hit_d = 1'b0;  // unmapped: error answer, reads zero
    end
  end

  // one wait state: ready rises the cycle after the access phase opens,
  // so read data always come from a flop and never from the decoder
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ready_q  <= 1'b0;
      slvErr_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      ready_q <= setup;
      if (setup) begin
        slvErr_q <= ~hit_d;
        rdData_q <= apbReq.pwrite ? '0 : rdData_d;
      end
    end
  end

  assign prdata  = rdData_q;
  assign pready  = ready_q;
  assign pslverr = slvErr_q;

  // control register: bypass level and self-clearing load strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bypass_q <= LPF_BYPASS_RST;
      load_q   <= 1'b0;
    end else begin
      load_q <= wrCtrl & apbReq.pwdata[LPF_CTRL_LOAD_BIT];
      if (wrCtrl) begin
        bypass_q <= apbReq.pwdata[LPF_CTRL_BYPASS_BIT];
      end
    end
  end

  // shadow coefficients; software edits them freely, the filter sees
  // nothing until a load, which avoids a half-updated tap set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shadow_q <= COEF_RST;
    end else if (wrCoef) begin
      shadow_q[coefOff_d[LPF_APB_AW-1:2] * COEF_W +: COEF_W] <=
        apbReq.pwdata[COEF_W-1:0];
    end
  end

  // pending flag: set by any coefficient write, set wins over the load
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q <= LPF_PEND_RST;
    end else if (wrCoef) begin
      pend_q <= 1'b1;
    end else if (load_q) begin
      pend_q <= 1'b0;
    end
  end

  // sticky clip flag: an event in the clearing cycle is kept
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sat_q <= LPF_SAT_RST;
    end else if (ovr_q) begin
      sat_q <= 1'b1;
    end else if (wrStat && apbReq.pwdata[LPF_STAT_SAT_BIT]) begin
      sat_q <= 1'b0;
    end
  end

  // active coefficient set, swapped in one edge after the load strobe
  lpf_coefficient_store #(
    .NCOEF   (NC),
    .CW      (COEF_W),
    .RST_VEC (COEF_RST)
  ) u_store (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .loadEn   (load_q),
    .loadData (shadow_q),
    .coefData (coefVec)
  );

  // sample history; window holds H words, oldest sample at index zero
  assign window = {dataIn, hist_q};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hist_q <= '0;
    end else begin
      hist_q <= window[H*WW-1:WW];
    end
  end

  // one polyphase branch per lane; all lanes of a word finish together
  for (genvar p = 0; p < LANES; p++) begin : g_lane
    logic signed [AW-1:0]       acc [NC+1];
    logic signed [AW-1:0]       rnd;
    logic        [SAMPLE_W-1:0] xMid;
    logic        [SAMPLE_W-1:0] y;
    logic                       c;
    localparam logic signed [AW-1:0] SMAX = AW'((1 << (SAMPLE_W-1)) - 1);
    localparam logic signed [AW-1:0] SMIN = AW'(-(1 << (SAMPLE_W-1)));

    assign acc[0] = '0;
    // the fixed window offset is the lane shift that hides group delay
    assign xMid   = window[(OFF+p-G)*SAMPLE_W +: SAMPLE_W];

    // preadd_mac_stage chain; the pair sharing tap i is summed first,
    // halving the multipliers at the cost of one wider adder each
    for (genvar i = 0; i < NC; i++) begin : g_stage
      logic signed [SAMPLE_W-1:0] xa;
      logic signed [SAMPLE_W-1:0] xb;
      logic signed [SAMPLE_W:0]   pre;
      logic signed [COEF_W-1:0]   h;
      logic signed [PW-1:0]       prod;

      assign xa = window[(OFF+p-i)*SAMPLE_W +: SAMPLE_W];
      if (i < G) begin : g_pair
        assign xb = window[(OFF+p-ORDER+i)*SAMPLE_W +: SAMPLE_W];
      end else begin : g_mid
        assign xb = '0;  // centre tap has no partner
      end
      assign h         = coefVec[i*COEF_W +: COEF_W];
      assign pre       = {xa[SAMPLE_W-1], xa} + {xb[SAMPLE_W-1], xb};
      assign prod      = pre * h;
      assign acc[i+1]  = acc[i] + AW'(prod);
    end

    // output_saturating_rounder: round half up, then clamp, never wrap
    assign rnd = (acc[NC] + (AW'(1) <<< (COEF_FRAC-1))) >>> COEF_FRAC;

    always_comb begin
      c = 1'b0;
      y = rnd[SAMPLE_W-1:0];
      if (bypass_q) begin
        y = xMid;  // same latency as the filter path
      end else if (rnd > SMAX) begin
        y = SMAX[SAMPLE_W-1:0];
        c = 1'b1;
      end else if (rnd < SMIN) begin
        y = SMIN[SAMPLE_W-1:0];
        c = 1'b1;
      end
    end

    assign filt_d[p*SAMPLE_W +: SAMPLE_W] = y;
    assign clip_d[p] = c;
  end

  // output flops load every cycle; the bus here has no valid qualifier
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataOut_q <= '0;
      ovr_q     <= 1'b0;
    end else begin
      dataOut_q <= filt_d;
      ovr_q     <= |clip_d;
    end
  end

  assign dataOut   = dataOut_q;
  assign overRange = ovr_q;

  // helper: cycles for which bypass has been steady out of reset
  logic [3:0] byCnt_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !bypass_q) begin
      byCnt_q <= 4'h0;
    end else if (byCnt_q != 4'hf) begin
      byCnt_q <= byCnt_q + 4'h1;
    end
  end

  a_bypass_align: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (int'(byCnt_q) > D + 1) |-> (dataOut_q == $past(dataIn, D + 1)))
    else $error("bypass output not input delayed by whole words");

  a_ready_wait: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (apbReq.psel && apbReq.penable && !ready_q) |=> ready_q)
    else $error("ready not raised one cycle into the access phase");

  a_ready_single: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ready_q |=> !ready_q)
    else $error("ready held for more than one cycle");

  a_load_commit: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    load_q |=> (coefVec == $past(shadow_q)) && !pend_q)
    else $error("load did not commit the shadow set");

  a_sat_sticky: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ovr_q |=> sat_q)
    else $error("clip event not caught in status");

  a_sat_hold: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (sat_q && !wrStat) |=> sat_q)
    else $error("clip flag dropped without a clear");

  a_sat_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (wrStat && apbReq.pwdata[LPF_STAT_SAT_BIT] && !ovr_q) |=> !sat_q)
    else $error("write one did not clear the clip flag");

  a_info_order: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (ready_q && !apbReq.pwrite && apbReq.paddr == LPF_OFF_INFO)
      |-> (prdata[LPF_INFO_ORDER_LSB +: 8] == 8'(ORDER)) && !pslverr)
    else $error("info register does not show the filter order");

  a_bypass_clean: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    bypass_q ##1 bypass_q |-> !ovr_q)
    else $error("clip reported while bypassed");

  // a refused access must never leak register contents onto the bus
  a_err_reads_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (pready && pslverr) |-> (prdata == '0))
    else $error("error answer carried nonzero read data");

endmodule

/* File: src/lpf_pkg.sv */
// lpf_pkg.sv: shared constants, register map and bus carrier for the fir
package lpf_pkg;

  // default filter shape
  localparam int LPF_ORDER_DEF     = 16;  // filter order
  localparam int LPF_LANES_DEF     = 4;   // parallel samples per data word
  localparam int LPF_SAMPLE_W_DEF  = 16;  // bits per sample
  localparam int LPF_COEF_W_DEF    = 16;  // bits per coefficient
  localparam int LPF_COEF_FRAC_DEF = 14;  // fractional coefficient bits

  // control bus geometry
  localparam int LPF_APB_AW  = 12;  // byte address width
  localparam int LPF_APB_DW  = 32;  // data width
  localparam int LPF_REG_CW  = 16;  // coefficient field width in a register

  // register byte offsets
  localparam logic [11:0] LPF_OFF_CTRL   = 12'h000;
  localparam logic [11:0] LPF_OFF_STATUS = 12'h004;
  localparam logic [11:0] LPF_OFF_INFO   = 12'h008;
  localparam logic [11:0] LPF_OFF_COEF0  = 12'h010;

  // field positions
  localparam int LPF_CTRL_BYPASS_BIT = 0;  // pass centre sample through
  localparam int LPF_CTRL_LOAD_BIT   = 1;  // commit shadow coefficients
  localparam int LPF_STAT_SAT_BIT    = 0;  // sticky clip flag, write 1 clears
  localparam int LPF_STAT_PEND_BIT   = 1;  // shadow written since the last load
  localparam int LPF_INFO_ORDER_LSB  = 0;  // filter order, 8 bits
  localparam int LPF_INFO_LANES_LSB  = 8;  // lanes per word, 8 bits

  // reset values
  localparam logic LPF_BYPASS_RST = 1'b0;
  localparam logic LPF_SAT_RST    = 1'b0;
  localparam logic LPF_PEND_RST   = 1'b0;

  // apb request from the master, one struct per cycle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lpf_apb_req_t;

  // ceil_log2_helper: bits needed to count v distinct values
  function automatic int lpf_ceil_log2(input int v);
    int r;
    r = 0;
    while ((1 << r) < v) r++;
    return r;
  endfunction

endpackage

/* File: src/lpf_coefficient_store.sv */
// lpf_coefficient_store.sv: active coefficient set, loaded as one word
module lpf_coefficient_store
  import lpf_pkg::*;
#(
  parameter int NCOEF = 9,                              // unique taps
  parameter int CW    = 16,                             // coefficient width
  parameter logic [NCOEF*CW-1:0] RST_VEC = '0           // set after reset
) (
  input  wire logic                sys_clk,   // data clock
  input  wire logic                sys_rst,   // sync reset, high
  input  wire logic                loadEn,    // one-cycle commit strobe
  input  wire logic [NCOEF*CW-1:0] loadData,  // shadow coefficients
  output logic      [NCOEF*CW-1:0] coefData   // active coefficients
);

  logic [NCOEF*CW-1:0] coef_q;

  // whole set swaps in one edge, so the filter never mixes old and new taps
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      coef_q <= RST_VEC;
    end else if (loadEn) begin
      coef_q <= loadData;
    end
  end

  assign coefData = coef_q;

endmodule

/* File: testbench/lpf_rt_source.sv */
// lpf_rt_source.sv: upstream real-time data path model, one word per clock
module lpf_rt_source
  import lpf_pkg::*;
#(
  parameter int LANES    = 4,   // samples per word
  parameter int SAMPLE_W = 16   // bits per sample
) (
  input  wire logic                      sys_clk,  // data clock
  input  wire logic                      start,    // begin a burst
  input  wire logic [7:0]                nWords,   // burst length in words
  output logic      [LANES*SAMPLE_W-1:0] dataIn    // word to the filter
);
  timeunit 1ns;
  timeprecision 1ps;

  int smp [0:1023];  // sample table, lane 0 of a word is the oldest
  int cnt = -1;      // word being sent, negative while idle

  initial dataIn = '0;

  // the real bus has no valid qualifier, so idle cycles carry zeros
  always @(posedge sys_clk) begin
    if (cnt < 0 && start)
      cnt = 0;
    for (int p = 0; p < LANES; p++)
      dataIn[p*SAMPLE_W+:SAMPLE_W] <=
        (cnt >= 0) ? SAMPLE_W'(smp[cnt*LANES+p]) : '0;
    if (cnt >= 0)
      cnt = (cnt + 1 < int'(nWords)) ? cnt + 1 : -1;
  end
endmodule

/* File: testbench/lpf_fir_top_tb.sv */
// lpf_fir_top_tb.sv: self-checking bench for the polyphase fir
module lpf_fir_top_tb;
  import lpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         sys_clk     = 1'b0;
  logic         sys_rst     = 1'b1;
  lpf_apb_req_t apbReq      = '0;
  logic         start       = 1'b0;
  logic [7:0]   nWords      = 8'h00;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         overRange;
  logic [63:0]  dataIn;
  logic [63:0]  dataOut;
  logic [31:0]  rd;
  logic         err;
  int           failures    = 0;
  int           comparisons = 0;
  int           h [0:8];      // active taps as the bench expects them
  bit           bypass      = 0;

  always #10 sys_clk = ~sys_clk;

  // defaults give order 16, four lanes, 16-bit samples and Q2.14 taps
  lpf_fir_top i_lpf_fir_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataIn(dataIn), .dataOut(dataOut), .overRange(overRange));

  lpf_rt_source #(.LANES(4), .SAMPLE_W(16)) i_lpf_rt_source (
    .sys_clk(sys_clk), .start(start), .nWords(nWords), .dataIn(dataIn));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; entered right after a rising edge, waits for ready
  // as long as it takes, so only the watchdog can end a hung access
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, e);
    chk("pslverr", {31'h0, err}, {31'h0, ee});
  endtask

  function automatic int sx(input int n);
    return (n < 0 || n > 1023) ? 0 : i_lpf_rt_source.smp[n];
  endfunction

  // symmetric taps, round half up, then clamp to the sample range
  function automatic void yref(input int n, output int y, output bit c);
    longint acc = 0;
    c = 0;
    if (bypass) begin
      y = sx(n);
      return;
    end
    for (int k = -8; k <= 8; k++)
      acc += longint'(h[k < 0 ? 8 + k : 8 - k]) * sx(n + k);
    acc = (acc + 8192) >>> 14;
    c = acc > 32767 || acc < -32768;
    y = acc > 32767 ? 32767 : acc < -32768 ? -32768 : int'(acc);
  endfunction

  task automatic fill(input int nw, input int mode);
    for (int n = 0; n < 1024; n++)
      i_lpf_rt_source.smp[n] = n >= nw * 4 ? 0 :
        mode == 0 ? (n * 7919) % 65536 - 32768 :
        mode == 1 ? (n == 20 ? 16384 : (n * 3001) % 4001 - 2000) :
        (n % 3 == 0 ? 30000 : n % 3 == 1 ? -30000 : n % 7 - 3);
  endtask

  // word j is driven after edge j+1 from start, sampled at edge j+2, and
  // its filtered result stands after edge j+4
  task automatic play(input int nw);
    int y;
    bit c;
    bit anyc;
    nWords <= 8'(nw);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int cy = 2; cy < nw + 8; cy++) begin
      @(posedge sys_clk);
      #1;
      if (cy >= 4) begin
        anyc = 0;
        for (int p = 0; p < 4; p++) begin
          yref((cy - 4) * 4 + p, y, c);
          anyc |= c;
          chk("dataOut", {16'h0, dataOut[p*16+:16]}, {16'h0, 16'(y)});
        end
        chk("overRange", {31'h0, overRange}, {31'h0, anyc});
      end
    end
    @(posedge sys_clk);
  endtask

  // shadow writes with junk above the field, then an atomic commit
  task automatic load();
    for (int i = 0; i < 9; i++)
      wr(LPF_OFF_COEF0 + 12'(4 * i), {16'hbeef, 16'(h[i])});
    rdchk(LPF_OFF_COEF0, {16'h0, 16'(h[0])}, 1'b0);
    rdchk(LPF_OFF_STATUS, 32'h2, 1'b0);
    wr(LPF_OFF_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    rdchk(LPF_OFF_STATUS, 32'h0, 1'b0);
    rdchk(LPF_OFF_CTRL, 32'h0, 1'b0);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end

  initial begin
    h = '{0, 0, 0, 0, 0, 0, 0, 0, 16384};
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(LPF_OFF_CTRL, 32'h0, 1'b0);
    rdchk(LPF_OFF_STATUS, 32'h0, 1'b0);
    rdchk(LPF_OFF_INFO, 32'h0000_0410, 1'b0);
    wr(LPF_OFF_INFO, 32'hffff_ffff);
    rdchk(LPF_OFF_INFO, 32'h0000_0410, 1'b0);
    rdchk(12'h00c, 32'h0, 1'b1);
    rdchk(12'h011, 32'h0, 1'b1);
    $display("test reset_regs done");
    fill(40, 0);
    play(40);
    $display("test unity_stream done");
    h = '{-3, 5, -20, 40, -100, 300, -800, 2500, 8192};
    load();
    fill(30, 1);
    play(30);
    $display("test symmetric_taps done");
    h = '{0, 0, 0, 0, 0, 0, 0, 0, 32767};
    load();
    fill(30, 2);
    play(30);
    rdchk(LPF_OFF_STATUS, 32'h1, 1'b0);
    wr(LPF_OFF_STATUS, 32'h1);
    rdchk(LPF_OFF_STATUS, 32'h0, 1'b0);
    $display("test saturation done");
    wr(LPF_OFF_CTRL, 32'h1);
    bypass = 1;
    rdchk(LPF_OFF_CTRL, 32'h1, 1'b0);
    play(30);
    rdchk(LPF_OFF_STATUS, 32'h0, 1'b0);
    $display("test bypass done");
    print_verdict();
  end
endmodule
